// ### rtl/io_serdes_gearbox.sv
// input deserializer and output serializer gearboxes
// assumes: core_clk_in faster than fast_edge_clock_in, mode static
`timescale 1ns/1ns
module io_serdes_gearbox
  import io_serdes_gearbox_pkg::*;
(
  // core side clock, reset, configuration
  input  wire logic                             core_clk_in,
  input  wire logic                             srst_in,
  input  wire io_serdes_gearbox_pkg::gear_mode_t mode_in,
  // input gearbox
  input  wire logic                             word_align_request_in,
  output logic [io_serdes_gearbox_pkg::WORD_W-1:0] q_out,
  output logic                                  q_valid_out,
  // output gearbox
  input  wire logic [io_serdes_gearbox_pkg::WORD_W-1:0] d_in,
  output logic                                  d_taken_out,
  // link side
  input  wire logic                             fast_edge_clock_in,
  input  wire logic                             lane_a_slot_din_in,
  input  wire logic                             lane_c_slot_din_in,
  output logic [1:0]                            lane_a_slot_dout_out,
  output logic [1:0]                            lane_c_slot_dout_out
);
  import io_serdes_gearbox_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // core clock domain state
  typedef struct packed {
    logic [2:0]        wt_sync;  // word toggle sync, bit2 last seen
    logic [WORD_W-1:0] q;        // stage three word
    logic              q_vld;    // new word pulse
    logic              al_tog;   // alignment request toggle
    logic [WORD_W-1:0] d_hold;   // output stage one word
    logic              d_req;    // handover request toggle
    logic [1:0]        ack_sync; // handover ack sync
    logic              d_taken;  // core word taken pulse
  } core_st_t;

  // fast clock domain state
  typedef struct packed {
    logic [1:0]                     rs;      // reset sync
    logic [1:0][1:0]                md;      // mode sync, two 2-bit stages
    logic [2:0]                     al_sync; // align toggle sync
    logic [2:0]                     rq_sync; // request sync, bit2 ack
    logic [LANES-1:0][SHIFT_W-1:0]  sh;      // input bit staging
    logic [LANES-1:0][PEND_W-1:0]   pend;    // staged input bits
    logic [3:0]                     lc_word; // last lane c word
    logic [WORD_W-1:0]              hw;      // assembled word
    logic                           wtog;    // word ready toggle
    logic [WORD_W-1:0]              w;       // output stage two word
    logic [LANES-1:0][SHIFT_W-1:0]  osh;     // output bit staging
    logic [LANES-1:0][PEND_W-1:0]   opend;   // staged output bits
    logic [LANES-1:0][1:0]          so;      // serial bit pairs
  } fast_st_t;

  core_st_t c_r;   // core registered state
  core_st_t c_nxt; // core next state
  fast_st_t f_r;   // fast registered state
  fast_st_t f_nxt; // fast next state

  logic [LANES-1:0] cap_rise; // older bit of each pair
  logic [LANES-1:0] cap_fall; // newer bit of each pair
  logic             frst;     // fast domain reset
  gear_mode_t       fmode;    // mode seen by fast logic

  assign frst  = f_r.rs[1];
  assign fmode = gear_mode_t'(f_r.md[1]);

  ////////////////////////////////////////////////////////////////////
  // capture delayed lane data
  generate
    for (genvar g = 0; g < LANES; g++) begin : g_cap
      ddr_capture u_cap (
        .clk_in   (fast_edge_clock_in),
        .rst_in   (frst),
        .din_in   (g == 0 ? lane_a_slot_din_in : lane_c_slot_din_in),
        .rise_out (cap_rise[g]),
        .fall_out (cap_fall[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // core domain next state
  always_comb begin
    c_nxt          = c_r;
    c_nxt.q_vld    = 1'b0;
    c_nxt.d_taken  = 1'b0;
    c_nxt.wt_sync  = {c_r.wt_sync[1:0], f_r.wtog};
    c_nxt.ack_sync = {c_r.ack_sync[0], f_r.rq_sync[2]};
    if (c_r.wt_sync[2] != c_r.wt_sync[1]) begin
      c_nxt.q     = f_r.hw;
      c_nxt.q_vld = 1'b1;
    end
    if (word_align_request_in) begin
      c_nxt.al_tog = ~c_r.al_tog;
    end
    // stage one takes core word once fast side acked
    if (c_r.ack_sync[1] == c_r.d_req) begin
      c_nxt.d_hold  = d_in;
      c_nxt.d_req   = ~c_r.d_req;
      c_nxt.d_taken = 1'b1;
    end
    if (srst_in) begin
      c_nxt = '0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    c_r <= c_nxt;
  end

  ////////////////////////////////////////////////////////////////////
  // fast domain next state
  always_comb begin
    logic [4:0]  n;
    logic [15:0] bits;
    logic [15:0] word;
    logic        emit_a;
    n      = 5'h00;
    bits   = 16'h0000;
    word   = 16'h0000;
    emit_a = 1'b0;
    f_nxt  = f_r;
    f_nxt.rs      = {f_r.rs[0], srst_in};
    f_nxt.md      = {f_r.md[0], mode_in};
    f_nxt.al_sync = {f_r.al_sync[1:0], c_r.al_tog};
    f_nxt.rq_sync = {f_r.rq_sync[1:0], c_r.d_req};
    for (int i = 0; i < LANES; i++) begin
      n = lane_bits(fmode, i);
      f_nxt.sh[i]   = {cap_fall[i], cap_rise[i], f_r.sh[i][15:2]};
      f_nxt.pend[i] = f_r.pend[i] + BITS_ECK;
      // slip boundary by dropping the oldest bit
      if (f_r.al_sync[2] != f_r.al_sync[1] && f_nxt.pend[i] != 5'h00) begin
        f_nxt.pend[i] = f_nxt.pend[i] - 5'h01;
      end
      // update when a full word is staged
      if (f_nxt.pend[i] >= n) begin
        word = (f_nxt.sh[i] >> (5'h10 - f_nxt.pend[i])) & low_mask(n);
        f_nxt.pend[i] = f_nxt.pend[i] - n;
        if (i == 0) begin
          emit_a = 1'b1;
        end else begin
          f_nxt.lc_word = word[3:0];
        end
        // lane a high nibble, lane c low nibble in dual mode
        if (i == 0) begin
          f_nxt.hw = (fmode == MODE_DUAL4) ? {word[3:0], f_nxt.lc_word}
                                           : word[7:0];
        end
      end
    end
    if (emit_a) begin
      f_nxt.wtog = ~f_r.wtog;
    end
    // take handed word into fast registers
    if (f_r.rq_sync[2] != f_r.rq_sync[1]) begin
      f_nxt.w = c_r.d_hold;
    end
    for (int i = 0; i < LANES; i++) begin
      n = lane_bits(fmode, i);
      bits = (i == 0) ? {8'h00, f_r.w} & low_mask(n)
                      : {12'h000, f_r.w[7:4]};
      f_nxt.osh[i]   = f_r.osh[i];
      f_nxt.opend[i] = f_r.opend[i];
      if (f_r.opend[i] < BITS_ECK) begin
        f_nxt.osh[i]   = f_r.osh[i] | 16'(bits << f_r.opend[i]);
        f_nxt.opend[i] = f_r.opend[i] + n;
      end
      // shift out two bits per edge clock cycle
      f_nxt.so[i]    = f_nxt.osh[i][1:0];
      f_nxt.osh[i]   = f_nxt.osh[i] >> 2;
      f_nxt.opend[i] = f_nxt.opend[i] - BITS_ECK;
    end
    // fast side reset, syncs keep running
    if (frst) begin
      f_nxt = '0;
      f_nxt.rs      = {f_r.rs[0], srst_in};
      f_nxt.md      = {f_r.md[0], mode_in};
      f_nxt.al_sync = {f_r.al_sync[1:0], c_r.al_tog};
      f_nxt.rq_sync = {f_r.rq_sync[1:0], c_r.d_req};
    end
  end

  always_ff @(posedge fast_edge_clock_in) begin
    f_r <= f_nxt;
  end

  // outputs straight from registers
  assign q_out                = c_r.q;
  assign q_valid_out          = c_r.q_vld;
  assign d_taken_out          = c_r.d_taken;
  assign lane_a_slot_dout_out = f_r.so[0];
  assign lane_c_slot_dout_out = f_r.so[1];

  ////////////////////////////////////////////////////////////////////
  // checks on the core domain
  AST_Q_FROM_HELD: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    q_valid_out |-> q_out == f_r.hw)
    else $error("word to core differs from assembled word");

  AST_VALID_PULSE: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    q_valid_out |=> !q_valid_out)
    else $error("word valid held longer than one cycle");

  AST_D_STAGE_ONE: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    d_taken_out |-> c_r.d_hold == $past(d_in))
    else $error("stage one did not hold the core word");

  AST_CORE_RESET: assert property (
    @(posedge core_clk_in)
    srst_in |=> (q_out == WORD_RST && !q_valid_out && !d_taken_out))
    else $error("core side not cleared by reset");

  // checks on the fast domain
  AST_FAST_RESET: assert property (
    @(posedge fast_edge_clock_in)
    frst |=> (f_r.pend[0] == 5'h00 && f_r.opend[0] == 5'h00))
    else $error("fast side staging not cleared by reset");

  AST_STAGE_TWO: assert property (
    @(posedge fast_edge_clock_in) disable iff (frst)
    (f_r.rq_sync[2] != f_r.rq_sync[1]) |=> f_r.w == $past(c_r.d_hold))
    else $error("stage two missed the handed word");

  AST_SERIAL_OUT: assert property (
    @(posedge fast_edge_clock_in) disable iff (frst)
    (f_r.opend[0] >= BITS_ECK) |=> lane_a_slot_dout_out ==
      $past(f_r.osh[0][1:0]))
    else $error("serial pair not taken from staging");

  AST_VIDEO_TOP: assert property (
    @(posedge fast_edge_clock_in) disable iff (frst)
    (f_r.wtog != $past(f_r.wtog) && fmode == MODE_VIDEO7)
      |-> f_r.hw[7] == 1'b0)
    else $error("video word uses bit seven");

  AST_PEND_BOUND: assert property (
    @(posedge fast_edge_clock_in) disable iff (frst)
    f_r.pend[0] < 5'h09)
    else $error("input staging overran a word");

endmodule

// ### rtl/io_serdes_gearbox_pkg.sv
// constants and types shared by the gearbox files
// assumes: one fast core clock and one slower edge clock
package io_serdes_gearbox_pkg;

  // gearing modes, held static while running
  typedef enum logic [1:0] {
    MODE_VIDEO7 = 2'b00,  // 1:7 and 7:1
    MODE_QUAD8  = 2'b01,  // 1:8 and 8:1
    MODE_DUAL4  = 2'b10   // two lanes of 1:4 and 4:1
  } gear_mode_t;

  localparam int         WORD_W   = 8;      // core word width
  localparam int         SHIFT_W  = 16;     // bit staging width
  localparam int         PEND_W   = 5;      // staged bit count width
  localparam int         LANES    = 2;      // lane a and lane c
  localparam logic [4:0] BITS_V7  = 5'h07;  // video word size
  localparam logic [4:0] BITS_Q8  = 5'h08;  // quad-rate word size
  localparam logic [4:0] BITS_D4  = 5'h04;  // double-rate word size
  localparam logic [4:0] BITS_ECK = 5'h02;  // bits per edge clock cycle
  localparam logic [7:0] WORD_RST = 8'h00;  // reset value of words

  // word size of a lane; lane c uses the double-rate size in every mode
  function automatic logic [4:0] lane_bits(gear_mode_t m, int lane);
    if (m == MODE_DUAL4 || lane != 0) return BITS_D4;
    if (m == MODE_QUAD8) return BITS_Q8;
    return BITS_V7;
  endfunction

  // low-bit mask of a given size
  function automatic logic [15:0] low_mask(logic [4:0] n);
    return 16'((17'h1 << n) - 17'h1);
  endfunction

endpackage

// ### rtl/ddr_capture.sv
// dual-edge capture of one serial lane on the fast edge clock
// assumes: din_in is the delayed pad data, asynchronous to any clock
`timescale 1ns/1ns
module ddr_capture (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // serial data
  input  wire logic din_in,
  // bit pair, older bit first
  output logic      rise_out,
  output logic      fall_out
);

  typedef struct packed {
    logic rise;      // bit taken at the rising edge
    logic rise_old;  // rising bit from one cycle back
    logic fall;      // falling bit moved onto the rising edge
  } cap_t;

  cap_t st_r;   // registered state
  cap_t st_nxt; // next state
  logic fall_neg_r; // falling-edge capture flop

  ////////////////////////////////////////////////////////////////////
  // falling edge capture
  always_ff @(negedge clk_in) begin
    if (rst_in) begin
      fall_neg_r <= 1'b0;
    end else begin
      fall_neg_r <= din_in;
    end
  end

  // pair the two edges, rising bit of the earlier half first
  always_comb begin
    st_nxt          = st_r;
    st_nxt.rise     = din_in;
    st_nxt.rise_old = st_r.rise;
    st_nxt.fall     = fall_neg_r;
    if (rst_in) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    st_r <= st_nxt;
  end

  assign rise_out = st_r.rise_old;
  assign fall_out = st_r.fall;

endmodule

// ### dv/gearbox_line_model.sv
// serial line model at the link pins: bit source and bit sink
// assumes: free-running link clock from the bench, patterns static
`timescale 1ns/1ns
module gearbox_line_model (
  // link clock
  input  wire logic        fast_clk_in,
  // lane patterns and their lengths
  input  wire logic [7:0]  pat_a_in,
  input  wire logic [7:0]  pat_c_in,
  input  wire logic [4:0]  len_a_in,
  input  wire logic [4:0]  len_c_in,
  // link pins
  output logic             din_a_out,
  output logic             din_c_out,
  input  wire logic [1:0]  dout_a_in,
  input  wire logic [1:0]  dout_c_in,
  // recent serial output, oldest bit lowest
  output logic [15:0]      hist_a_out,
  output logic [15:0]      hist_c_out
);
  int pos_a = 0;  // next lane a bit
  int pos_c = 0;  // next lane c bit

  initial begin
    din_a_out  = 1'b0;
    din_c_out  = 1'b0;
    hist_a_out = 16'h0000;
    hist_c_out = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // source: one bit on every link edge, pattern bit0 first
  always @(posedge fast_clk_in or negedge fast_clk_in) begin
    din_a_out <= pat_a_in[pos_a];
    din_c_out <= pat_c_in[pos_c];
    pos_a = (pos_a + 1) % int'(len_a_in);
    pos_c = (pos_c + 1) % int'(len_c_in);
  end

  ////////////////////////////////////////////////////////////////////////////
  // sink: pair bit0 is earlier in time, so it lands lower
  always @(posedge fast_clk_in) begin
    hist_a_out <= {dout_a_in[1], dout_a_in[0], hist_a_out[15:2]};
    hist_c_out <= {dout_c_in[1], dout_c_in[0], hist_c_out[15:2]};
  end
endmodule

// ### dv/io_serdes_gearbox_test.sv
// bench: per mode, word order, boundary slip and serial order checks
// assumes: line model on the link pins, mode changed only under reset
`timescale 1ns/1ns
module io_serdes_gearbox_test;
  import io_serdes_gearbox_pkg::*;
  logic       core_clk_in = 1'b0;   // core clock, 8 ns
  logic       fast_clk    = 1'b0;   // link clock, 30 ns
  logic       srst_in     = 1'b1;   // core reset
  gear_mode_t mode_r      = MODE_QUAD8;
  logic       align_r     = 1'b0;   // slip request
  logic [7:0] d_r         = 8'h00;  // serializer word
  logic [7:0] pat_a       = 8'h00;  // lane a source pattern
  logic [7:0] pat_c       = 8'h00;  // lane c source pattern
  logic [4:0] len_a       = 5'h08;
  logic [4:0] len_c       = 5'h08;
  logic [7:0] q_out;
  logic       q_valid_out;
  logic       d_taken_out;
  logic       din_a;
  logic       din_c;
  logic [1:0] dout_a;
  logic [1:0] dout_c;
  logic [15:0] hist_a;
  logic [15:0] hist_c;
  int         n_errors  = 0;
  int         cmp_count = 0;
  int         cycles    = 0;

  always #4 core_clk_in = ~core_clk_in;
  // link clock runs beside the core clock
  always #15 fast_clk = ~fast_clk;

  io_serdes_gearbox io_serdes_gearbox_i (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .mode_in(mode_r),
    .word_align_request_in(align_r), .q_out(q_out),
    .q_valid_out(q_valid_out), .d_in(d_r), .d_taken_out(d_taken_out),
    .fast_edge_clock_in(fast_clk), .lane_a_slot_din_in(din_a),
    .lane_c_slot_din_in(din_c), .lane_a_slot_dout_out(dout_a),
    .lane_c_slot_dout_out(dout_c));

  gearbox_line_model gearbox_line_model_i (
    .fast_clk_in(fast_clk), .pat_a_in(pat_a), .pat_c_in(pat_c),
    .len_a_in(len_a), .len_c_in(len_c), .din_a_out(din_a),
    .din_c_out(din_c), .dout_a_in(dout_a), .dout_c_in(dout_c),
    .hist_a_out(hist_a), .hist_c_out(hist_c));

  ////////////////////////////////////////////////////////////////////////////
  // compares and helpers
  task automatic cmp_word(string nm, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_flag(string nm, logic e, logic g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  // true if the first m bits of w run through p cyclically
  function automatic logic rot_ok(logic [15:0] w, logic [7:0] p,
                                  int n, int m);
    logic ok;
    for (int k = 0; k < n; k++) begin
      ok = 1'b1;
      for (int i = 0; i < m; i++) if (w[i] !== p[(i + k) % n]) ok = 1'b0;
      if (ok) return 1'b1;
    end
    return 1'b0;
  endfunction

  // word once its oldest bit is dropped
  function automatic logic [7:0] slip(logic [7:0] w, int n);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < n; i++) r[i] = w[(i + 1) % n];
    return r;
  endfunction

  // wait for k pulses of q_valid_out (tk low) or d_taken_out (tk high)
  task automatic wait_q(int k, logic tk);
    repeat (k) do begin @(posedge core_clk_in); #1; end
      while ((tk ? d_taken_out : q_valid_out) !== 1'b1);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // one mode: reset, word order, slip, serial order
  task automatic run_mode(gear_mode_t m, int n, logic [7:0] pa,
                          logic [7:0] pc, logic [7:0] d);
    logic [7:0] w;
    logic [7:0] e;
    int         nl;
    nl = (m == MODE_DUAL4) ? 4 : n;
    @(posedge core_clk_in);
    mode_r <= m;
    pat_a <= pa;
    pat_c <= pc;
    d_r <= d;
    len_a <= 5'(nl);
    len_c <= 5'(nl);
    srst_in <= 1'b1;
    repeat (20) @(posedge core_clk_in);
    #1;
    cmp_word("q_out in reset", 8'h00, q_out);
    cmp_flag("q_valid_out in reset", 1'b0, q_valid_out);
    cmp_flag("d_taken_out in reset", 1'b0, d_taken_out);
    cmp_word("dout in reset", 8'h00, {4'h0, dout_a, dout_c});
    @(posedge core_clk_in);
    srst_in <= 1'b0;
    wait_q(4, 1'b0);
    w = q_out;
    cmp_flag("lane a word", 1'b1, rot_ok(16'(m == MODE_DUAL4 ? w >> 4 : w),
             pa, nl, nl));
    if (m == MODE_DUAL4)
      cmp_flag("lane c word", 1'b1, rot_ok(16'(w & 8'h0f), pc, 4, 4));
    if (m == MODE_VIDEO7) cmp_flag("q_out bit7", 1'b0, w[7]);
    // one-cycle slip request from the core
    @(posedge core_clk_in);
    align_r <= 1'b1;
    @(posedge core_clk_in);
    align_r <= 1'b0;
    // words already in flight when the slip lands are skipped
    wait_q(6, 1'b0);
    e = (m == MODE_DUAL4) ? ((slip(w >> 4, 4) << 4) | slip(w & 8'h0f, 4))
                          : slip(w, n);
    cmp_word("q_out after slip", e, q_out);
    wait_q(3, 1'b1);
    repeat (12) @(posedge fast_clk);
    #1;
    cmp_flag("lane a stream", 1'b1, rot_ok(hist_a,
             (m == MODE_DUAL4) ? d & 8'h0f : d, nl, 16));
    if (m == MODE_DUAL4)
      cmp_flag("lane c stream", 1'b1, rot_ok(hist_c, d >> 4, 4, 16));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence over all three modes
  initial begin
    run_mode(MODE_VIDEO7, 7, 8'h4d, 8'h4d, 8'hb5);
    run_mode(MODE_QUAD8, 8, 8'h1d, 8'h1d, 8'hc5);
    run_mode(MODE_DUAL4, 4, 8'h0b, 8'h01, 8'h3e);
    report_and_stop();
  end

  // hang guard, far above the expected run length
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
endmodule
